// file: smbus_cfg_regs.svh
// offsets, field positions, reset values and bus addresses of the config port
// assumes inclusion by bare name from the design module
`ifndef SMBUS_CFG_REGS_SVH
`define SMBUS_CFG_REGS_SVH

`define CFG_WRITE_ADDR      8'hD2
`define CFG_READ_ADDR       8'hD3
`define CFG_BYTE0_OFFSET    8'h00
`define CFG_BYTE1_OFFSET    8'h01
`define CFG_COUNT_OFFSET    8'h08
`define CFG_LINK_TYPE_BIT   7
`define CFG_STORAGE_BIT     6
`define CFG_REF_HI_BIT      5
`define CFG_REF_LO_BIT      3
`define CFG_USB_HI_BIT      2
`define CFG_USB_LO_BIT      1
`define CFG_SPREAD_BIT      0
`define CFG_BYTE0_RESET     6'h3E
`define CFG_BYTE1_RESET     8'hFF
`define CFG_COUNT_RESET     8'h00
`define CFG_DEFAULT_READ_COUNT 8'h02
`define CFG_STRAP_SETTLE    2'h3

`endif

// file: smbus_cfg_pkg.sv
// types shared by the config port
// assumes nothing beyond a SystemVerilog compiler
package smbus_cfg_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK} port_state_t;
    typedef enum logic [1:0] {PH_ADDR, PH_INDEX, PH_COUNT, PH_DATA} byte_phase_t;
    typedef struct packed {
        logic [2:0] referenceEnable;  // [2] out0, [1] out1, [0] out2
        logic [1:0] usbEnable;        // [1] clock1, [0] clock0
        logic [7:0] sourcePairEnable; // bit n for pair n
        logic       spreadEnable;
    } clock_enables_t;
endpackage : smbus_cfg_pkg

// file: smbus_indexed_block_config_port.sv
// management bus slave holding configuration bytes 0, 1 and the read count byte 8
// assumes scl and sda arrive asynchronously; sda is open drain, resolved outside
// assumes outputLowPhase levels come from the clock outputs, asynchronous to mclk
//
// What this block does
// - data stored at consecutive indexes, each acked
// - acknowledge every received byte except a foreign address, before next
// - read address acknowledged after repeated start
// - byte count sent first on reads
// - then consecutive bytes from loaded index
// - byte 8 sets the reported count, reads run to host nack
// - release data line on host not-acknowledge
// - byte 0 bit 7 latched link strap
// - byte 0 bit 6 latched storage strap
// - reference and usb enables default one
// - spread enable bit 0 defaults off
// - byte 1 source pair enables, default one
module smbus_indexed_block_config_port (
    input  wire logic                          mclk,            // 200 MHz system clock
    input  wire logic                          reset_n,         // async reset, active low
    input  wire logic                          sclIn,           // bus clock pin
    input  wire logic                          sdaIn,           // bus data pin level
    input  wire logic                          linkTypeStrap,   // link clock type strap pin
    input  wire logic                          storageSelStrap, // storage pair strap pin
    input  wire logic [12:0]                   outputLowPhase,  // high while that output is low
    output logic                               sdaOut,          // data pin drive value
    output logic                               sdaOe,           // data pin pulled low when high
    output smbus_cfg_pkg::clock_enables_t      enables          // output enables, gated except spreadEnable
);
    import smbus_cfg_pkg::*;
    `include "smbus_cfg_regs.svh"

    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic        rstMeta;
    logic        rstSync;
    logic [1:0]  sclPipe;
    logic [1:0]  sdaPipe;
    logic [1:0]  strapMeta;
    logic [1:0]  strapSync;
    logic [12:0] lowMeta;
    logic [12:0] lowPhase;
    logic        sclPrev;
    logic        sdaPrev;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    always_ff @(posedge mclk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            sclPipe   <= 2'h3;
            sdaPipe   <= 2'h3;
            sclPrev   <= 1'b1;
            sdaPrev   <= 1'b1;
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
            lowMeta   <= 13'h0;
            lowPhase  <= 13'h0;
        end
        else
        begin
            sclPipe   <= {sclPipe[0], sclIn};
            sdaPipe   <= {sdaPipe[0], sdaIn};
            sclPrev   <= sclPipe[1];
            sdaPrev   <= sdaPipe[1];
            strapMeta <= {linkTypeStrap, storageSelStrap};
            strapSync <= strapMeta;
            lowMeta   <= outputLowPhase;
            lowPhase  <= lowMeta;
        end
    end

    logic sclS;
    logic sdaS;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;

    assign sclS     = sclPipe[1];
    assign sdaS     = sdaPipe[1];
    assign sclRise  = sclS & ~sclPrev;
    assign sclFall  = ~sclS & sclPrev;
    assign startDet = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopDet  = sclS & sclPrev & ~sdaPrev & sdaS;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release, once the synchronisers have filled
    logic [1:0] strapCnt;
    logic [1:0] next_strapCnt;
    logic [1:0] strapLatch;
    logic [1:0] next_strapLatch;
    logic       strapDone;

    assign strapDone = (strapCnt == `CFG_STRAP_SETTLE);

    always_comb
    begin
        next_strapCnt   = strapCnt;
        next_strapLatch = strapLatch;
        if (!strapDone)
        begin
            next_strapCnt = strapCnt + 2'h1;
            if (strapCnt == `CFG_STRAP_SETTLE - 2'h1)
                next_strapLatch = strapSync;
        end
    end

    always_ff @(posedge mclk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            strapCnt   <= 2'h0;
            strapLatch <= 2'h0;
        end
        else
        begin
            strapCnt   <= next_strapCnt;
            strapLatch <= next_strapLatch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // protocol sequencing and configuration storage
    port_state_t state;
    port_state_t next_state;
    byte_phase_t phase;
    byte_phase_t next_phase;
    logic [3:0]  bitCnt;
    logic [3:0]  next_bitCnt;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic [7:0]  pointer;
    logic [7:0]  next_pointer;
    logic [7:0]  remaining;
    logic [7:0]  next_remaining;
    logic        readMode;
    logic        next_readMode;
    logic        next_sdaOe;
    logic [5:0]  cfg0;
    logic [5:0]  next_cfg0;
    logic [7:0]  cfg1;
    logic [7:0]  next_cfg1;
    logic [7:0]  cfg8;
    logic [7:0]  next_cfg8;
    logic        cfg8Written;
    logic        next_cfg8Written;
    logic [7:0]  readCount;

    assign readCount = cfg8Written ? cfg8 : `CFG_DEFAULT_READ_COUNT;

    function automatic logic [7:0] readByte(input logic [7:0] idx);
        unique case (idx)
            `CFG_BYTE0_OFFSET: readByte = {strapLatch, cfg0};
            `CFG_BYTE1_OFFSET: readByte = cfg1;
            `CFG_COUNT_OFFSET: readByte = cfg8;
            default:           readByte = 8'h00;
        endcase
    endfunction : readByte

    always_comb
    begin
        next_state       = state;
        next_phase       = phase;
        next_bitCnt      = bitCnt;
        next_shift       = shift;
        next_pointer     = pointer;
        next_remaining   = remaining;
        next_readMode    = readMode;
        next_sdaOe       = sdaOe;
        next_cfg0        = cfg0;
        next_cfg1        = cfg1;
        next_cfg8        = cfg8;
        next_cfg8Written = cfg8Written;
        if (startDet)
        begin
            next_state  = ST_RX;
            next_phase  = PH_ADDR;
            next_bitCnt = 4'h0;
            next_sdaOe  = 1'b0;
        end
        else if (stopDet)
        begin
            next_state = ST_IDLE;
            next_sdaOe = 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE: ;
                ST_RX:
                    if (sclRise)
                    begin
                        next_shift  = {shift[6:0], sdaS};
                        next_bitCnt = bitCnt + 4'h1;
                    end
                    else if (sclFall && bitCnt == 4'h8)
                    begin
                        next_state  = ST_RXACK;
                        next_sdaOe  = 1'b1;
                        next_bitCnt = 4'h0;
                        unique case (phase)
                            PH_ADDR:
                                if (shift == `CFG_WRITE_ADDR)
                                begin
                                    next_readMode = 1'b0;
                                    next_phase    = PH_INDEX;
                                end
                                else if (shift == `CFG_READ_ADDR)
                                    next_readMode = 1'b1;
                                else
                                begin
                                    next_state = ST_IDLE;
                                    next_sdaOe = 1'b0;
                                end
                            PH_INDEX:
                            begin
                                next_pointer = shift;
                                next_phase   = PH_COUNT;
                            end
                            PH_COUNT:
                            begin
                                next_remaining = shift;
                                next_phase     = PH_DATA;
                            end
                            PH_DATA:
                                if (remaining != 8'h00)
                                begin
                                    unique case (pointer)
                                        `CFG_BYTE0_OFFSET: next_cfg0 = shift[5:0];
                                        `CFG_BYTE1_OFFSET: next_cfg1 = shift;
                                        `CFG_COUNT_OFFSET:
                                        begin
                                            next_cfg8        = shift;
                                            next_cfg8Written = 1'b1;
                                        end
                                        default: ;
                                    endcase
                                    next_pointer   = pointer + 8'h01;
                                    next_remaining = remaining - 8'h01;
                                end
                        endcase
                    end
                ST_RXACK:
                    if (sclFall)
                    begin
                        if (readMode)
                        begin
                            next_state = ST_TX;
                            next_shift = readCount;
                            next_sdaOe = ~readCount[7];
                        end
                        else
                        begin
                            next_state = ST_RX;
                            next_sdaOe = 1'b0;
                        end
                    end
                ST_TX:
                    if (sclFall)
                    begin
                        if (bitCnt == 4'h7)
                        begin
                            next_state = ST_TXACK;
                            next_sdaOe = 1'b0;
                        end
                        else
                        begin
                            next_shift  = {shift[6:0], 1'b0};
                            next_sdaOe  = ~shift[6];
                            next_bitCnt = bitCnt + 4'h1;
                        end
                    end
                ST_TXACK:
                    if (sclRise)
                    begin
                        if (sdaS)
                            next_state = ST_IDLE;
                        else
                        begin
                            next_shift   = readByte(pointer);
                            next_pointer = pointer + 8'h01;
                            next_bitCnt  = 4'h0;
                        end
                    end
                    else if (sclFall && bitCnt == 4'h0)
                    begin
                        next_state = ST_TX;
                        next_sdaOe = ~shift[7];
                    end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            state       <= ST_IDLE;
            phase       <= PH_ADDR;
            bitCnt      <= 4'h0;
            shift       <= 8'h00;
            pointer     <= 8'h00;
            remaining   <= 8'h00;
            readMode    <= 1'b0;
            sdaOe       <= 1'b0;
            cfg0        <= `CFG_BYTE0_RESET;
            cfg1        <= `CFG_BYTE1_RESET;
            cfg8        <= `CFG_COUNT_RESET;
            cfg8Written <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            phase       <= next_phase;
            bitCnt      <= next_bitCnt;
            shift       <= next_shift;
            pointer     <= next_pointer;
            remaining   <= next_remaining;
            readMode    <= next_readMode;
            sdaOe       <= next_sdaOe;
            cfg0        <= next_cfg0;
            cfg1        <= next_cfg1;
            cfg8        <= next_cfg8;
            cfg8Written <= next_cfg8Written;
        end
    end

    assign sdaOut = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // enables except spread follow the register only while the affected output sits low
    logic [12:0] wantEnable;
    logic [12:0] gatedEnable;

    assign wantEnable = {cfg0[`CFG_REF_HI_BIT:`CFG_USB_LO_BIT], cfg1};

    genvar g;
    generate
        for (g = 0; g < 13; g++)
        begin : gate_g
            always_ff @(posedge mclk or negedge rstSync)
            begin
                if (!rstSync)
                    gatedEnable[g] <= 1'b1;
                else if (lowPhase[g])
                    gatedEnable[g] <= wantEnable[g];
            end
        end
    endgenerate

    assign enables.referenceEnable  = gatedEnable[12:10];
    assign enables.usbEnable        = gatedEnable[9:8];
    assign enables.sourcePairEnable = gatedEnable[7:0];
    assign enables.spreadEnable     = cfg0[`CFG_SPREAD_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync);

    wire rxByteEnd = state == ST_RX && sclFall && bitCnt == 4'h8;

    read_addr_ack_a: assert property (rxByteEnd && phase == PH_ADDR && shift == `CFG_READ_ADDR
        |=> sdaOe && readMode && state == ST_RXACK) else $error("read address not acked");
    ack_each_byte_a: assert property (rxByteEnd && phase != PH_ADDR
        |=> sdaOe ##1 (sdaOe || sclFall || startDet || stopDet)) else $error("byte not acked");
    pair_store_a: assert property (rxByteEnd && phase == PH_DATA && remaining != 8'h00
        && pointer == `CFG_BYTE1_OFFSET |=> cfg1 == $past(shift)) else $error("byte 1 not stored");
    count_first_a: assert property (state == ST_RXACK && readMode && sclFall && !startDet
        && !stopDet |=> state == ST_TX && shift == $past(readCount)) else $error("count not first");
    pointer_step_a: assert property (state == ST_TXACK && sclRise && !sdaS && !startDet
        && !stopDet |=> pointer == $past(pointer) + 8'h01) else $error("pointer not advanced");
    nack_release_a: assert property (state == ST_TXACK && sclRise && sdaS && !startDet
        && !stopDet |=> !sdaOe && state == ST_IDLE) else $error("line held after nack");
    strap_hold_a: assert property (strapDone |=> $stable(strapLatch))
        else $error("strap readback changed");
    enable_reset_a: assert property ($rose(rstSync) |-> cfg0 == `CFG_BYTE0_RESET
        && cfg1 == `CFG_BYTE1_RESET) else $error("enable defaults wrong");
    count_bound_a: assert property (cfg8Written |-> readCount == cfg8)
        else $error("read count not from byte 8");
    low_gate_a: assert property (##1 ((gatedEnable ^ $past(gatedEnable)) & ~$past(lowPhase))
        == 13'h0) else $error("enable changed while output high");

    write_seen_c: cover property (rxByteEnd && phase == PH_DATA && !readMode);
    read_seen_c:  cover property (state == ST_RXACK && readMode && sclFall);
    nack_seen_c:  cover property (state == ST_TXACK && sclRise && sdaS);
    gate_seen_c:  cover property (lowPhase[0] && gatedEnable[0] != wantEnable[0]);
endmodule : smbus_indexed_block_config_port

// file: smbus_host_model.sv
// management bus host model: start, repeated start, stop, byte send and byte receive
// assumes an open-drain data line with a pull-up; the device drive arrives as sdaOe/sdaOut
module smbus_host_model (
    input  wire logic mclk,    // system clock, used only to pick a frame phase
    input  wire logic sdaOe,   // device pulls data low when high
    input  wire logic sdaOut,  // device drive value
    output logic      sclLine, // bus clock, stands high outside frames
    output wire logic sdaLine  // resolved data line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic    hostLow = 1'h0;
    realtime stretch = 0;

    initial
    begin
        sclLine = 1'h1;
    end

    // pull-up: a released line reads high
    assign sdaLine = (sdaOe ? sdaOut : 1'h1) & ~hostLow;

    ////////////////////////////////////////////////////////////////////////////////
    // frame phase is offset from the mclk grid so no bus edge lands on a clock edge
    task automatic startCond();
        @(negedge mclk);
        #0.3 hostLow = 1'h0;
        #16 sclLine = 1'h1;
        #16 hostLow = 1'h1;
        #16 sclLine = 1'h0;
        #16;
    endtask : startCond

    task automatic stopCond();
        hostLow = 1'h1;
        #16 sclLine = 1'h1;
        #16 hostLow = 1'h0;
        #16;
    endtask : stopCond

    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            hostLow = ~b[i];
            #16 sclLine = 1'h1;
            #32 sclLine = 1'h0;
            #(16 + stretch);
        end
        hostLow = 1'h0;
        #16 sclLine = 1'h1;
        #16 ack = ~sdaLine;
        #16 sclLine = 1'h0;
        #16;
    endtask : sendByte

    task automatic recvByte(output logic [7:0] b, input logic nack);
        hostLow = 1'h0;
        for (int i = 0; i < 8; i++)
        begin
            // low time of 32 ns keeps the device's data change, about three
            // system clocks after the fall, well inside the low phase
            #32 sclLine = 1'h1;
            #16 b = {b[6:0], sdaLine};
            #16 sclLine = 1'h0;
            #(stretch);
        end
        hostLow = ~nack;
        #16 sclLine = 1'h1;
        #32 sclLine = 1'h0;
        #16 hostLow = 1'h0;
    endtask : recvByte
endmodule : smbus_host_model

// file: testbench.sv
// self-checking bench for the config port: block writes and reads through the host model
// assumes the host model owns the bus and resolves the open-drain data line
module testbench;
    import smbus_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic           mclk = 1'h0;
    logic           reset_n = 1'h0;
    logic           linkTypeStrap = 1'h1;
    logic           storageSelStrap = 1'h0;
    logic [12:0]    outputLowPhase = 13'h1FFF;
    wire logic      sclIn;
    wire logic      sdaIn;
    logic           sdaOut;
    logic           sdaOe;
    clock_enables_t enables;
    int             badCount = 0;
    int             checked = 0;
    logic [7:0]     rx;
    logic           ack;

    smbus_indexed_block_config_port u_smbus_indexed_block_config_port (
        .mclk            (mclk),
        .reset_n         (reset_n),
        .sclIn           (sclIn),
        .sdaIn           (sdaIn),
        .linkTypeStrap   (linkTypeStrap),
        .storageSelStrap (storageSelStrap),
        .outputLowPhase  (outputLowPhase),
        .sdaOut          (sdaOut),
        .sdaOe           (sdaOe),
        .enables         (enables)
    );

    smbus_host_model u_smbus_host_model (
        .mclk    (mclk),
        .sdaOe   (sdaOe),
        .sdaOut  (sdaOut),
        .sclLine (sclIn),
        .sdaLine (sdaIn)
    );

    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expected);
        checked++;
        if (seen !== expected)
        begin
            badCount++;
            $display("ERROR %s expected %h seen %h", name, expected, seen);
        end
    endtask : check

    task automatic closeOut();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : closeOut

    task automatic tx(input logic [7:0] b, input logic expAck);
        u_smbus_host_model.sendByte(b, ack);
        check("ack", 16'(ack), 16'(expAck));
    endtask : tx

    task automatic writeBlock(input logic [7:0] idx, input logic [7:0] cnt, input int n,
                              input logic [31:0] data);
        u_smbus_host_model.startCond();
        tx(8'hD2, 1'h1);
        tx(idx, 1'h1);
        tx(cnt, 1'h1);
        for (int i = 0; i < n; i++)
            tx(data[31 - 8 * i -: 8], 1'h1);
        u_smbus_host_model.stopCond();
    endtask : writeBlock

    task automatic readBlock(input logic [7:0] idx, input int n, input logic [7:0] expCount,
                             input logic [31:0] expData);
        u_smbus_host_model.startCond();
        tx(8'hD2, 1'h1);
        tx(idx, 1'h1);
        u_smbus_host_model.startCond();
        tx(8'hD3, 1'h1);
        u_smbus_host_model.recvByte(rx, 1'h0);
        check("count", 16'(rx), 16'(expCount));
        for (int i = 0; i < n; i++)
        begin
            u_smbus_host_model.recvByte(rx, i == n - 1);
            check("data", 16'(rx), 16'(expData[31 - 8 * i -: 8]));
        end
        repeat (4) @(negedge mclk);
        check("sdaOe", 16'(sdaOe), 16'h0000);
        u_smbus_host_model.stopCond();
    endtask : readBlock

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge mclk);
        reset_n = 1'h1;
        repeat (20) @(negedge mclk);
        // straps move after the latch; readback must keep the latched levels
        linkTypeStrap = 1'h0;
        storageSelStrap = 1'h1;
        check("enables", 16'(enables), 16'h3FFE);
        readBlock(8'h00, 2, 8'h02, 32'hBEFF_0000);
        // every output high: enable changes must wait for the low phase
        outputLowPhase = 13'h0000;
        writeBlock(8'h00, 8'h02, 2, 32'h41A5_0000);
        repeat (8) @(negedge mclk);
        check("enables", 16'(enables), 16'h3FFF);
        outputLowPhase = 13'h000F;
        repeat (8) @(negedge mclk);
        check("enables", 16'(enables), 16'h3FEB);
        outputLowPhase = 13'h1FFF;
        repeat (8) @(negedge mclk);
        check("enables", 16'(enables), 16'h014B);
        readBlock(8'h00, 2, 8'h02, 32'h81A5_0000);
        // a byte beyond the count is acknowledged but must not land in byte 1
        writeBlock(8'h00, 8'h01, 2, 32'h3E3C_0000);
        writeBlock(8'h08, 8'h01, 1, 32'h0300_0000);
        readBlock(8'h00, 3, 8'h03, 32'hBEA5_0000);
        // foreign address: no acknowledge
        u_smbus_host_model.startCond();
        tx(8'hA0, 1'h0);
        u_smbus_host_model.stopCond();
        // slow host with stretched clock low time
        u_smbus_host_model.stretch = 48;
        readBlock(8'h01, 1, 8'h03, 32'hA500_0000);
        closeOut();
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        badCount++;
        closeOut();
    end
endmodule : testbench
